/* File: hdl/sar_adc_pkg.sv */
package sar_adc_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int RESULT_BITS = 12;
  localparam int CONFIG_BITS = 2;
  localparam int CFG_MODE_POS = 1;
  localparam int CFG_ODD_POS = 0;
  localparam logic [CONFIG_BITS-1:0] CFG_RESET = 2'h2;
  localparam logic [RESULT_BITS-1:0] RESULT_RESET = 12'h000;

  // ----------------------------------------------------------------
  // Variants
  // ----------------------------------------------------------------
  localparam int CHANNELS_ONE = 1;
  localparam int CHANNELS_TWO = 2;
  localparam int SAMPLE_SHIFTS_ONE = 12;
  localparam int SAMPLE_SHIFTS_TWO = 10;
  localparam int CONFIG_SHIFTS_MIN = 2;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_PERIOD_PS = 50000;
  localparam int CONVERT_STROBE_TIME_TYP_NS = 3700;
  localparam int CONVERT_STROBE_TIME_MAX_NS = 4660;
  localparam int SAMPLE_RATE_MIN_KHZ = 150;
  // Longest time rounds down
  localparam int CONVERT_STROBE_CYCLES_MAX = (CONVERT_STROBE_TIME_MAX_NS * 1000) / SYS_PERIOD_PS;
  localparam int CONVERT_STROBE_CYCLES_TYP = (CONVERT_STROBE_TIME_TYP_NS * 1000) / SYS_PERIOD_PS;
  localparam int CONVERT_STROBE_CNT_BITS = 8;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SAMPLE = 3'b001,
    ST_CONVERT = 3'b010,
    ST_SLEEP = 3'b100
  } seq_state_type;

endpackage

/* File: hdl/level_sync.sv */
module level_sync #(
  parameter int STAGES = 2,
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_level,
  output logic o_level
);

  logic [STAGES-1:0] stage_q;

  initial begin
    if (STAGES < 2) begin
      $error("level_sync needs at least two stages");
    end
  end

  // First stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      stage_q <= {STAGES{RESET_VALUE}};
    end else begin
      stage_q <= {stage_q[STAGES-2:0], i_level};
    end
  end

  assign o_level = stage_q[STAGES-1];

endmodule

/* File: hdl/sar_adc_serial_control.sv */
// Behaviour
// - Strobe high starts a new conversion
// - Strobe held high after conversion: sleep
// - Strobe low drives the serial output
// - Conversion ends within the maximum time
// - Two-channel: config in, result out
// - Strobe rising releases the serial output
// - Bits change on falling shift edge
// - Extra shifts after the word give zeros
// - Two-channel: first two rising edges latch config
// - Config sets mode and channel next conversion
module sar_adc_serial_control #(
  parameter int CHANNELS = sar_adc_pkg::CHANNELS_TWO,
  parameter int CONVERT_STROBE_CYCLES = sar_adc_pkg::CONVERT_STROBE_CYCLES_TYP
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_clk_shift,
  input wire logic i_convert_strobe,
  input wire logic i_serial_config_in,
  input wire logic [sar_adc_pkg::RESULT_BITS-1:0] i_conversion_code,
  output logic o_serial_result_out,
  output logic o_serial_result_oe,
  output logic o_converting,
  output logic o_sleep,
  output logic o_sampling,
  output logic o_input_mode_select,
  output logic o_channel_odd
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  initial begin
    if (CHANNELS != sar_adc_pkg::CHANNELS_ONE && CHANNELS != sar_adc_pkg::CHANNELS_TWO) begin
      $error("CHANNELS must be 1 or 2");
    end
    if (CONVERT_STROBE_CYCLES < 1 || CONVERT_STROBE_CYCLES > sar_adc_pkg::CONVERT_STROBE_CYCLES_MAX) begin
      $error("CONVERT_STROBE_CYCLES outside the conversion time limit");
    end
  end

  localparam logic [sar_adc_pkg::CONVERT_STROBE_CNT_BITS-1:0] CONVERT_STROBE_LAST =
    sar_adc_pkg::CONVERT_STROBE_CNT_BITS'(CONVERT_STROBE_CYCLES - 1);
  localparam logic [3:0] WORD_LAST = 4'(sar_adc_pkg::RESULT_BITS);

  // ----------------------------------------------------------------
  // System domain: strobe synchroniser
  // ----------------------------------------------------------------
  logic strobe_sync;
  logic strobe_prev_q;
  logic strobe_rise;
  logic strobe_fall;

  level_sync #(
    .STAGES(sar_adc_pkg::SYNC_STAGES),
    .RESET_VALUE(1'b0)
  ) u_strobe_sync (
    .i_clk(i_clk_sys),
    .i_reset(i_reset),
    .i_level(i_convert_strobe),
    .o_level(strobe_sync)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      strobe_prev_q <= 1'b0;
    end else begin
      strobe_prev_q <= strobe_sync;
    end
  end

  assign strobe_rise = strobe_sync & ~strobe_prev_q;
  assign strobe_fall = ~strobe_sync & strobe_prev_q;

  // ----------------------------------------------------------------
  // System domain: conversion sequencer
  // ----------------------------------------------------------------
  sar_adc_pkg::seq_state_type state_q;
  logic [sar_adc_pkg::CONVERT_STROBE_CNT_BITS-1:0] convert_strobe_cnt_q;
  logic convert_strobe_end;
  logic frame_tgl_q;
  logic [sar_adc_pkg::RESULT_BITS-1:0] word_q;
  logic [sar_adc_pkg::CONFIG_BITS-1:0] cfg_link_q;
  logic [sar_adc_pkg::CONFIG_BITS-1:0] cfg_active_q;

  assign convert_strobe_end = (state_q == sar_adc_pkg::ST_CONVERT) && (convert_strobe_cnt_q == CONVERT_STROBE_LAST);

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_q <= sar_adc_pkg::ST_SAMPLE;
    end else begin
      unique case (state_q)
        sar_adc_pkg::ST_SAMPLE: begin
          if (strobe_rise) begin
            state_q <= sar_adc_pkg::ST_CONVERT;
          end
        end
        sar_adc_pkg::ST_CONVERT: begin
          // Early fall aborts; host must wait out the conversion
          if (strobe_fall) begin
            state_q <= sar_adc_pkg::ST_SAMPLE;
          end else if (convert_strobe_end) begin
            state_q <= sar_adc_pkg::ST_SLEEP;
          end
        end
        sar_adc_pkg::ST_SLEEP: begin
          if (strobe_fall) begin
            state_q <= sar_adc_pkg::ST_SAMPLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      convert_strobe_cnt_q <= '0;
    end else if (state_q != sar_adc_pkg::ST_CONVERT) begin
      convert_strobe_cnt_q <= '0;
    end else if (!convert_strobe_end) begin
      convert_strobe_cnt_q <= convert_strobe_cnt_q + 1'b1;
    end
  end

  // Toggle marks a new frame; steady for the whole frame after
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      frame_tgl_q <= 1'b0;
    end else if (state_q == sar_adc_pkg::ST_SAMPLE && strobe_rise) begin
      frame_tgl_q <= ~frame_tgl_q;
    end
  end

  // Result held from conversion end until the next conversion ends
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      word_q <= sar_adc_pkg::RESULT_RESET;
    end else if (convert_strobe_end && !strobe_fall) begin
      word_q <= i_conversion_code;
    end
  end

  // Config from link is quiet once strobe is high again
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cfg_active_q <= sar_adc_pkg::CFG_RESET;
    end else if (state_q == sar_adc_pkg::ST_SAMPLE && strobe_rise) begin
      cfg_active_q <= cfg_link_q;
    end
  end

  // ----------------------------------------------------------------
  // System domain: pin status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_serial_result_oe <= 1'b0;
    end else begin
      // Released at strobe rise, driven while low
      o_serial_result_oe <= ~strobe_sync;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_converting <= 1'b0;
      o_sleep <= 1'b0;
      o_sampling <= 1'b0;
      o_input_mode_select <= sar_adc_pkg::CFG_RESET[sar_adc_pkg::CFG_MODE_POS];
      o_channel_odd <= sar_adc_pkg::CFG_RESET[sar_adc_pkg::CFG_ODD_POS];
    end else begin
      o_converting <= (state_q == sar_adc_pkg::ST_CONVERT) && !convert_strobe_end;
      o_sleep <= (state_q == sar_adc_pkg::ST_SLEEP) || (convert_strobe_end && !strobe_fall);
      o_sampling <= (state_q == sar_adc_pkg::ST_SAMPLE) && !strobe_rise;
      o_input_mode_select <= cfg_active_q[sar_adc_pkg::CFG_MODE_POS];
      o_channel_odd <= cfg_active_q[sar_adc_pkg::CFG_ODD_POS];
    end
  end

  // ----------------------------------------------------------------
  // Link domain: reset and frame detection
  // ----------------------------------------------------------------
  // Shift clock stops between frames, so a frame is recognised by the
  // toggle changing rather than by any edge outside the frame.
  logic link_reset;
  logic tx_seen_q;
  logic rx_seen_q;
  logic [3:0] tx_cnt_q;
  logic [1:0] rx_cnt_q;
  logic tx_new;
  logic rx_new;

  level_sync #(
    .STAGES(sar_adc_pkg::SYNC_STAGES),
    .RESET_VALUE(1'b1)
  ) u_link_reset_sync (
    .i_clk(i_clk_shift),
    .i_reset(1'b0),
    .i_level(i_reset),
    .o_level(link_reset)
  );

  assign tx_new = frame_tgl_q != tx_seen_q;
  assign rx_new = frame_tgl_q != rx_seen_q;

  // ----------------------------------------------------------------
  // Link domain: result shifter on falling edge
  // ----------------------------------------------------------------
  always_ff @(negedge i_clk_shift) begin
    if (link_reset) begin
      tx_seen_q <= 1'b0;
      tx_cnt_q <= '0;
      o_serial_result_out <= 1'b0;
    end else if (tx_new) begin
      tx_seen_q <= frame_tgl_q;
      tx_cnt_q <= 4'h1;
      o_serial_result_out <= word_q[sar_adc_pkg::RESULT_BITS-1];
    end else if (tx_cnt_q < WORD_LAST) begin
      tx_cnt_q <= tx_cnt_q + 4'h1;
      o_serial_result_out <= word_q[4'(sar_adc_pkg::RESULT_BITS - 1) - tx_cnt_q];
    end else begin
      o_serial_result_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: config capture on rising edge
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_shift) begin
    if (link_reset) begin
      rx_seen_q <= 1'b0;
      rx_cnt_q <= '0;
      cfg_link_q <= sar_adc_pkg::CFG_RESET;
    end else if (CHANNELS == sar_adc_pkg::CHANNELS_ONE) begin
      rx_seen_q <= frame_tgl_q;
      rx_cnt_q <= '0;
      cfg_link_q <= sar_adc_pkg::CFG_RESET;
    end else if (rx_new) begin
      rx_seen_q <= frame_tgl_q;
      rx_cnt_q <= 2'h1;
      cfg_link_q[sar_adc_pkg::CFG_MODE_POS] <= i_serial_config_in;
    end else if (rx_cnt_q == 2'h1) begin
      rx_cnt_q <= 2'h2;
      cfg_link_q[sar_adc_pkg::CFG_ODD_POS] <= i_serial_config_in;
    end
  end

endmodule

/* File: bench/sar_adc_serial_control_sva.sv */
module sar_adc_serial_control_sva #(
  parameter int CONVERT_STROBE_CYCLES = 74
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_clk_shift,
  input wire logic i_convert_strobe,
  input wire logic [sar_adc_pkg::RESULT_BITS-1:0] i_conversion_code,
  input wire logic o_serial_result_out,
  input wire logic o_serial_result_oe,
  input wire logic o_converting,
  input wire logic o_sleep,
  input wire logic o_sampling
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // Helpers
  // ----
  logic [7:0] convert_strobe_len_q;
  logic [2:0] settle_q;
  logic [3:0] falls_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || !o_converting) begin
      convert_strobe_len_q <= 8'h00;
    end else begin
      convert_strobe_len_q <= convert_strobe_len_q + 8'h01;
    end
  end
  // Output enable needs a few edges after reset
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      settle_q <= 3'h0;
    end else if (settle_q != 3'h7) begin
      settle_q <= settle_q + 3'h1;
    end
  end
  // Shift clock idles while strobe is high, so strobe clears the count itself
  always_ff @(negedge i_clk_shift or posedge i_convert_strobe) begin
    if (i_convert_strobe || i_reset) begin
      falls_q <= 4'h0;
    end else if (falls_q != 4'hf) begin
      falls_q <= falls_q + 4'h1;
    end
  end
  // ----
  // Properties
  // ----
  chk_convert_strobe_start: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $rose(i_convert_strobe) && o_sampling |-> ##[1:6] o_converting)
    else $error("conversion did not start");
  chk_sleep_enter: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $fell(o_converting) && i_convert_strobe |-> ##[0:1] o_sleep)
    else $error("no sleep after conversion");
  chk_sleep_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_sleep && i_convert_strobe |=> o_sleep)
    else $error("sleep left with strobe high");
  chk_convert_strobe_length: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $fell(o_converting) && i_convert_strobe |->
    convert_strobe_len_q >= CONVERT_STROBE_CYCLES - 1 && convert_strobe_len_q <= CONVERT_STROBE_CYCLES)
    else $error("conversion length wrong");
  chk_out_release: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_convert_strobe [*4] |-> !o_serial_result_oe)
    else $error("serial output not released");
  chk_out_drive: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (settle_q == 3'h7 && !i_convert_strobe) [*4] |-> o_serial_result_oe)
    else $error("serial output not driven");
  chk_msb_order: assert property (@(posedge i_clk_shift) disable iff (i_reset)
    !i_convert_strobe && falls_q != 4'h0 && falls_q <= 4'hc |->
    o_serial_result_out == i_conversion_code[4'hc - falls_q])
    else $error("result bit out of order");
  chk_zero_fill: assert property (@(posedge i_clk_shift) disable iff (i_reset)
    !i_convert_strobe && falls_q > 4'hc |-> !o_serial_result_out)
    else $error("no zeros after word");
endmodule

bind sar_adc_serial_control sar_adc_serial_control_sva #(.CONVERT_STROBE_CYCLES(CONVERT_STROBE_CYCLES)) chk (
  .i_clk_sys, .i_reset, .i_clk_shift, .i_convert_strobe, .i_conversion_code,
  .o_serial_result_out, .o_serial_result_oe, .o_converting, .o_sleep, .o_sampling);

/* File: bench/sar_adc_host_model.sv */
module sar_adc_host_model (
  input wire logic i_clk_sys,
  input wire logic i_sdo_line,
  output logic o_clk_shift,
  output logic o_convert_strobe,
  output logic o_serial_config_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Shift clock idles high and stands still between frames
  initial begin
    o_clk_shift = 1'b1;
    o_convert_strobe = 1'b0;
    o_serial_config_in = 1'b0;
  end
  task automatic pulse(input int n);
    for (int i = 0; i < n; i++) begin
      #15 o_clk_shift = 1'b0;
      #15 o_clk_shift = 1'b1;
    end
  endtask
  task automatic convert(input int hold);
    @(posedge i_clk_sys) #2 o_convert_strobe = 1'b1;
    repeat (hold) @(posedge i_clk_sys);
  endtask
  task automatic frame(input logic [1:0] cfg, input int n, output logic [15:0] word);
    word = 16'h0000;
    @(posedge i_clk_sys) #2 o_convert_strobe = 1'b0;
    repeat (6) @(posedge i_clk_sys);
    for (int i = 0; i < n; i++) begin
      #15 o_clk_shift = 1'b0;
      o_serial_config_in = (i < 2) ? cfg[1-i] : ~o_serial_config_in;
      #15 o_clk_shift = 1'b1;
      word = {word[14:0], i_sdo_line};
    end
    if (n < 12) #(30 * (12 - n));
    #30;
  endtask
endmodule

/* File: bench/sar_adc_serial_control_tb.sv */
module sar_adc_serial_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CONVERT_STROBE_CYC = 4;
  localparam int HOLD = 96;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [11:0] code = 12'h000;
  logic clk_shift, strobe, cfg_in, serial_result_out, sdo_oe, sdo_line;
  logic converting, sleep, sampling, mode_sel, chan_odd;
  int failures = 0;
  int compares = 0;
  always #25 clk_sys = ~clk_sys;
  assign sdo_line = sdo_oe ? serial_result_out : 1'bz;
  sar_adc_serial_control #(.CONVERT_STROBE_CYCLES(CONVERT_STROBE_CYC)) dut (
    .i_clk_sys(clk_sys), .i_reset(reset), .i_clk_shift(clk_shift),
    .i_convert_strobe(strobe), .i_serial_config_in(cfg_in), .i_conversion_code(code),
    .o_serial_result_out(serial_result_out), .o_serial_result_oe(sdo_oe), .o_converting(converting),
    .o_sleep(sleep), .o_sampling(sampling), .o_input_mode_select(mode_sel),
    .o_channel_odd(chan_odd));
  sar_adc_host_model host (
    .i_clk_sys(clk_sys), .i_sdo_line(sdo_line), .o_clk_shift(clk_shift),
    .o_convert_strobe(strobe), .o_serial_config_in(cfg_in));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Config of one frame shows at the next conversion
  task automatic t_round(input logic [1:0] prev, input logic [1:0] cfg, input int n);
    logic [15:0] word;
    @(posedge clk_sys) #2 code = code + 12'h9a5;
    host.convert(HOLD);
    check({13'h0000, sleep, sdo_oe, converting}, 16'h0004);
    check({14'h0000, mode_sel, chan_odd}, {14'h0000, prev});
    host.frame(cfg, n, word);
    check(word, {code, 4'h0} >> (16 - n));
    check({13'h0000, sleep, sampling, sdo_oe}, 16'h0003);
    $display("test round cfg %h bits %0d done", cfg, n);
  endtask
  initial begin
    #200us;
    failures++;
    conclude();
  end
  initial begin
    fork
      host.pulse(4);
      repeat (16) @(posedge clk_sys);
    join
    #2 reset = 1'b0;
    // Link reset only clears on shift edges, so flush it before a frame
    host.pulse(3);
    repeat (4) @(posedge clk_sys);
    check({10'h000, sdo_oe, converting, sleep, sampling, mode_sel, chan_odd}, 16'h0026);
    $display("test reset done");
    t_round(sar_adc_pkg::CFG_RESET, 2'h0, 16);
    t_round(2'h0, 2'h1, 12);
    t_round(2'h1, 2'h2, 2);
    t_round(2'h2, 2'h3, 16);
    t_round(2'h3, 2'h1, 13);
    conclude();
  end
endmodule
